// ===== qcrg_defines.svh
/*
  Constants of the quad clock request gating block: register offsets,
  field positions, reset values, widths and driver type codes.
  Assumes inclusion by bare name from qcrg_pkg.sv and the top module.
*/
`ifndef QCRG_DEFINES_SVH
`define QCRG_DEFINES_SVH

// Register byte offsets
`define QCRG_OFF_CTRL     12'h000
`define QCRG_OFF_DRIVE    12'h004
`define QCRG_OFF_STATUS   12'h008

// Control register fields
`define QCRG_CTRL_W       16
`define QCRG_F_REQPOL     3:0
`define QCRG_F_SWREQ      7:4
`define QCRG_B_FORCE      8
`define QCRG_B_OUTPOL     9
`define QCRG_F_DRVTYPE    11:10
`define QCRG_B_ACMODE     12
`define QCRG_B_SKEWINV    13
`define QCRG_B_LDO_ON     14
`define QCRG_B_SHUTDOWN   15
`define QCRG_CTRL_RST     16'h0000

// Drive register: two bits per output
`define QCRG_DRIVE_W      8
`define QCRG_DRIVE_RST    8'h00

// Status register fields
`define QCRG_ST_OT        0
`define QCRG_ST_OUTS      4:1
`define QCRG_ST_SRCREQ    5
`define QCRG_ST_W         6

// Source request driver types
`define QCRG_DRV_PP       2'h0
`define QCRG_DRV_OD       2'h1
`define QCRG_DRV_OS       2'h2

// Skew stage index width; each stage lags the previous by one system clock
`define QCRG_SKEW_W       2
`define QCRG_ZERO_WORD    32'h0000_0000

`endif

// ===== qcrg_pkg.sv
/*
  Types of the quad clock request gating block.
  Assumes qcrg_defines.svh is on the include path.
*/
`include "qcrg_defines.svh"
package qcrg_pkg;
  typedef struct packed {
    logic       shutdown;
    logic       ldo_on;
    logic       skew_inv;
    logic       ac_mode;
    logic [1:0] drv_type;
    logic       out_pol;
    logic       force_req;
    logic [3:0] sw_req;
    logic [3:0] req_pol;
  } qcrg_ctrl_s;

  typedef struct packed {
    logic       oe;
    logic       level;
  } qcrg_pin_s;
endpackage

// ===== qcrg_top.sv
/*
  Quad clock request gating: four gated, skewed clock outputs, a source
  clock request, regulator and input-stage control, APB registers.
  Assumes the source clock and request pins are asynchronous to
  clk_sys_i; the source clock is sampled as a level, so the gated
  outputs are a replica of it at the system clock's resolution.
*/
`include "qcrg_defines.svh"
module qcrg_top
  import qcrg_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        srst_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        src_clk_i,
  input  wire logic [3:0]  per_output_request_in_i,
  input  wire logic        dev_enable_i,
  input  wire logic        over_temp_i,
  output logic             clock_output_one_o,
  output logic             clock_output_two_o,
  output logic             clock_output_three_o,
  output logic             clock_output_four_o,
  output logic [7:0]       drive_step_o,
  output logic             src_req_out_o,
  output logic             src_req_oe_o,
  output logic             ldo_en_o,
  output logic             in_stage_en_o,
  output logic             ac_mode_o,
  output logic             ac_bias_en_o,
  output logic             low_power_o
);
  // Two-flop synchronisers for all pin inputs
  logic [3:0] req_s1_ff, req_s2_ff;
  logic       clk_s1_ff, clk_s2_ff, clk_s3_ff;
  logic       en_s1_ff, en_s2_ff;
  logic       ot_s1_ff, ot_s2_ff;
  always_ff @(posedge clk_sys_i) begin
    req_s1_ff <= per_output_request_in_i;
    req_s2_ff <= req_s1_ff;
    clk_s1_ff <= src_clk_i;
    clk_s2_ff <= clk_s1_ff;
    clk_s3_ff <= clk_s2_ff;
    en_s1_ff  <= dev_enable_i;
    en_s2_ff  <= en_s1_ff;
    ot_s1_ff  <= over_temp_i;
    ot_s2_ff  <= ot_s1_ff;
  end

  // Registers; reset models battery power-up, not the enable pin
  qcrg_ctrl_s ctrl_ff;
  logic [`QCRG_DRIVE_W-1:0] drive_ff;
  logic ot_flag_ff;

  // APB decode: zero wait states, unmapped address errors
  wire acc      = psel_i & penable_i;
  wire hit_ctrl = (paddr_i == `QCRG_OFF_CTRL);
  wire hit_drv  = (paddr_i == `QCRG_OFF_DRIVE);
  wire hit_st   = (paddr_i == `QCRG_OFF_STATUS);
  wire mapped   = hit_ctrl | hit_drv | hit_st;
  wire wr_ctrl  = acc & pwrite_i & hit_ctrl;
  wire wr_drv   = acc & pwrite_i & hit_drv;
  wire wr_st    = acc & pwrite_i & hit_st;

  // Request logic, always alive even in low power
  wire [3:0] pin_act  = req_s2_ff ^ ctrl_ff.req_pol;
  wire [3:0] want     = pin_act | ctrl_ff.sw_req;
  wire       halted   = ot_flag_ff | ctrl_ff.shutdown;
  wire       any_req  = |want;
  wire       src_act  = any_req | ctrl_ff.force_req;
  wire       src_fall = clk_s3_ff & ~clk_s2_ff;

  // Gate enables change only at a source falling edge, so the source clock
  // is low at both switch points; lagging or inverted taps can still be cut short
  logic [3:0] gate_ff;
  wire  [3:0] nxt_gate = src_fall ? (want & {4{~halted}}) : gate_ff;
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) gate_ff <= 4'h0;
    else        gate_ff <= nxt_gate;
  end

  // Skew chain: each output lags the previous by one system clock, which
  // spreads the switching edges; invert mode groups them in pairs
  logic [3:0] dly_ff;
  wire        base = clk_s2_ff;
  wire  [3:0] nxt_dly = {dly_ff[2:0], base};
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) dly_ff <= 4'h0;
    else        dly_ff <= nxt_dly;
  end
  wire [3:0] tap_skew = dly_ff;
  wire [3:0] tap_inv  = {~dly_ff[1], dly_ff[1], ~dly_ff[0], dly_ff[0]};
  wire [3:0] tap      = ctrl_ff.skew_inv ? tap_inv : tap_skew;

  // Gating forces zero; an inverted tap idles high only while gated on
  wire [3:0] nxt_out = tap & gate_ff;
  logic [3:0] out_ff;
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) out_ff <= 4'h0;
    else        out_ff <= nxt_out;
  end
  assign clock_output_one_o   = out_ff[0];
  assign clock_output_two_o   = out_ff[1];
  assign clock_output_three_o = out_ff[2];
  assign clock_output_four_o  = out_ff[3];

  // Source request pin with polarity and driver style
  wire lvl = src_act ^ ctrl_ff.out_pol;
  qcrg_pin_s nxt_pin;
  always_comb begin
    nxt_pin.level = lvl;
    nxt_pin.oe    = 1'b1;
    case (ctrl_ff.drv_type)
      `QCRG_DRV_PP: nxt_pin.oe = 1'b1;
      `QCRG_DRV_OD: nxt_pin.oe = ~lvl;
      `QCRG_DRV_OS: nxt_pin.oe = lvl;
      default:      nxt_pin.oe = 1'b1;
    endcase
  end
  qcrg_pin_s pin_ff;
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) pin_ff <= '0;
    else        pin_ff <= nxt_pin;
  end
  assign src_req_out_o = pin_ff.level;
  assign src_req_oe_o  = pin_ff.oe;

  // Power controls; over-temperature turns off the regulator, input stage and AC bias
  wire nxt_ldo   = (any_req | ctrl_ff.ldo_on) & ~ot_flag_ff;
  wire nxt_in_en = ~halted & en_s2_ff;
  wire nxt_bias  = ctrl_ff.ac_mode & src_act & nxt_in_en;
  wire nxt_lp    = ~en_s2_ff;
  logic ldo_ff, in_en_ff, bias_ff, lp_ff, ac_ff;
  logic [7:0] drv_o_ff;
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      ldo_ff   <= 1'b0;
      in_en_ff <= 1'b0;
      bias_ff  <= 1'b0;
      lp_ff    <= 1'b1;
      ac_ff    <= 1'b0;
      drv_o_ff <= `QCRG_DRIVE_RST;
    end else begin
      ldo_ff   <= nxt_ldo;
      in_en_ff <= nxt_in_en;
      bias_ff  <= nxt_bias;
      lp_ff    <= nxt_lp;
      ac_ff    <= ctrl_ff.ac_mode;
      drv_o_ff <= drive_ff;
    end
  end
  assign ldo_en_o      = ldo_ff;
  assign in_stage_en_o = in_en_ff;
  assign ac_bias_en_o  = bias_ff;
  assign low_power_o   = lp_ff;
  assign ac_mode_o     = ac_ff;
  assign drive_step_o  = drv_o_ff;

  // Register writes land at the access edge; enable pin never clears them
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      ctrl_ff  <= `QCRG_CTRL_RST;
      drive_ff <= `QCRG_DRIVE_RST;
    end else begin
      if (wr_ctrl) ctrl_ff  <= pwdata_i[`QCRG_CTRL_W-1:0];
      if (wr_drv)  drive_ff <= pwdata_i[`QCRG_DRIVE_W-1:0];
    end
  end

  // Over-temperature flag: sticky, write one clears, set wins
  wire ot_clr = wr_st & pwdata_i[`QCRG_ST_OT];
  wire nxt_ot = ot_s2_ff | (ot_flag_ff & ~ot_clr);
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) ot_flag_ff <= 1'b0;
    else        ot_flag_ff <= nxt_ot;
  end

  // Read mux and response
  logic [`QCRG_ST_W-1:0] st;
  always_comb begin
    st = '0;
    st[`QCRG_ST_OT]     = ot_flag_ff;
    st[`QCRG_ST_OUTS]   = gate_ff;
    st[`QCRG_ST_SRCREQ] = src_act;
  end
  wire [31:0] rd_mux =
    hit_ctrl ? {16'h0000, ctrl_ff} :
    hit_drv  ? {24'h000000, drive_ff} :
    hit_st   ? {26'h0000000, st} : `QCRG_ZERO_WORD;
  logic [31:0] prdata_ff;
  logic        pready_ff, pslverr_ff;
  wire [31:0] nxt_rdata = (psel_i & ~penable_i & ~pwrite_i) ? rd_mux
                                                           : prdata_ff;
  wire setup = psel_i & ~penable_i;
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      prdata_ff  <= `QCRG_ZERO_WORD;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      prdata_ff  <= nxt_rdata;
      pready_ff  <= setup;
      pslverr_ff <= setup & ~mapped;
    end
  end
  assign prdata_o  = prdata_ff;
  assign pready_o  = pready_ff;
  assign pslverr_o = pslverr_ff;
endmodule

// ===== qcrg_assertions.sv
/*
  Concurrent checks on the register port and AC bias of qcrg_top.
  Assumes it is bound into qcrg_top; defines on the include path.
*/
`include "qcrg_defines.svh"
module qcrg_assertions (
  input wire logic        clk_sys_i,
  input wire logic        srst_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic        ac_mode_o,
  input wire logic        ac_bias_en_o
);
  timeunit 1ns;
  timeprecision 1ps;
  wire logic mapped = paddr_i inside
    {`QCRG_OFF_CTRL, `QCRG_OFF_DRIVE, `QCRG_OFF_STATUS};
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);
  sequence setup_s;
    psel_i && !penable_i;
  endsequence
  sequence rd_setup_s;
    psel_i && !penable_i && !pwrite_i;
  endsequence
  // Wait-free slave: one ready pulse per setup, error only for holes
  AST_READY: assert property (setup_s |=> pready_o)
    else $error("no ready after setup");
  AST_PULSE: assert property (pready_o |=> !pready_o)
    else $error("ready longer than one cycle");
  AST_ERR: assert property (setup_s |=> pslverr_o == !mapped)
    else $error("error flag wrong for address");
  AST_ERR_RDY: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  AST_RD0: assert property (pready_o && pslverr_o && !pwrite_i
    |-> prdata_o == 32'h0)
    else $error("unmapped read not zero");
  AST_STATUS: assert property (pready_o && !pwrite_i && paddr_i ==
    `QCRG_OFF_STATUS |-> prdata_o[31:6] == 26'h0)
    else $error("status upper bits set");
  // Read data only moves on a read setup, so software sees a steady word
  AST_HOLD: assert property (!(psel_i && !penable_i && !pwrite_i)
    |=> $stable(prdata_o))
    else $error("read data moved");
  AST_BIAS: assert property (ac_bias_en_o |-> ac_mode_o)
    else $error("bias outside AC mode");
endmodule
bind qcrg_top qcrg_assertions u_chk (.clk_sys_i(clk_sys_i),
  .srst_i(srst_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .ac_mode_o(ac_mode_o),
  .ac_bias_en_o(ac_bias_en_o));

// ===== qcrg_osc_model.sv
/*
  Upstream oscillator model: runs the source clock only while asked.
  Assumes the bench tells it the active sense of the request.
*/
module qcrg_osc_model (
  input  wire logic clk_sys_i,
  input  wire logic srst_i,
  input  wire logic req_i,
  input  wire logic act_lo_i,
  input  wire logic slow_i,
  output logic      src_clk_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0]       cnt_ff;
  wire  logic       on  = (req_i ^ act_lo_i) && !srst_i;
  wire  logic [4:0] lim = slow_i ? 5'h14 : 5'h03;
  // Warm up, then toggle every third cycle; parks low when not asked
  always @(posedge clk_sys_i) begin
    if (!on) begin
      cnt_ff    <= 5'h00;
      src_clk_o <= 1'b0;
    end else if (cnt_ff != lim) begin
      cnt_ff <= cnt_ff + 5'h01;
    end else begin
      cnt_ff    <= lim - 5'h02;
      src_clk_o <= ~src_clk_o;
    end
  end
endmodule

// ===== qcrg_tb.sv
/*
  Self-checking bench for qcrg_top over APB and the request pins.
  Assumes qcrg_osc_model stands in for the upstream oscillator.
*/
`include "qcrg_defines.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys_i, srst_i, psel, pen, pwr, den, ot, er, lo, slow;
  logic [11:0] padr;
  logic [31:0] pwd, rd;
  logic [3:0]  req;
  wire  [31:0] prd;
  wire  [3:0]  o;
  wire  [7:0]  drv;
  wire         rdy, err, sclk, sreq, soe, ldo, ins, acm, acb, lp;
  int          failures, cmp_count;
  qcrg_top dut (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(padr), .pwdata_i(pwd),
    .prdata_o(prd), .pready_o(rdy), .pslverr_o(err), .src_clk_i(sclk),
    .per_output_request_in_i(req), .dev_enable_i(den), .over_temp_i(ot),
    .clock_output_one_o(o[0]), .clock_output_two_o(o[1]),
    .clock_output_three_o(o[2]), .clock_output_four_o(o[3]),
    .drive_step_o(drv), .src_req_out_o(sreq), .src_req_oe_o(soe),
    .ldo_en_o(ldo), .in_stage_en_o(ins), .ac_mode_o(acm),
    .ac_bias_en_o(acb), .low_power_o(lp));
  qcrg_osc_model osc (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
    .req_i(sreq), .act_lo_i(lo), .slow_i(slow), .src_clk_o(sclk));
  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end
  task chk(input logic ok, input string m);
    cmp_count++;
    if (ok !== 1'b1) begin
      failures++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  // Request held until ready is sampled; then a few settling cycles
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwr  <= w;
    padr <= a;
    pwd  <= d;
    @(posedge clk_sys_i);
    pen <= 1'b1;
    repeat (20) begin
      @(posedge clk_sys_i);
      if (rdy === 1'b1) break;
    end
    if (rdy !== 1'b1) begin
      failures++;
      $display("wrong value at %0t: no ready", $time);
    end
    rd = prd;
    er = err;
    psel <= 1'b0;
    pen  <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
  endtask
  task wc(input logic [31:0] d);
    apb(1'b1, `QCRG_OFF_CTRL, d);
  endtask
  // Toggles of one output over a span long enough for the sync path
  task seen(input int i, output int t);
    logic p;
    t = 0;
    p = o[i];
    repeat (200) begin
      @(posedge clk_sys_i);
      t += int'(o[i] !== p);
      p = o[i];
    end
  endtask
  task t_regs;
    apb(1'b0, `QCRG_OFF_CTRL, 32'h0);
    chk(rd === 32'h0 && drv === 8'h00, "defaults");
    apb(1'b0, 12'h00c, 32'h0);
    chk(er === 1'b1 && rd === 32'h0, "hole");
    apb(1'b1, `QCRG_OFF_DRIVE, 32'h0000_00e4);
    chk(drv === 8'he4, "drive");
  endtask
  task t_gate;
    int t;
    req <= 4'h9;
    seen(0, t);
    chk(t > 8 && sreq === 1'b1 && ldo === 1'b1, "start");
    chk(o[1] === 1'b0 && o[2] === 1'b0, "unasked");
    repeat (6) @(posedge clk_sys_i) chk(o[3] === ~o[0], "skew");
    req <= 4'hf;
    wc(32'h0000_2000);
    repeat (20) @(posedge clk_sys_i);
    repeat (6) @(posedge clk_sys_i) chk(o[1] === ~o[0] && o[3] === ~o[2],
      "invert");
    wc(32'h0);
    req <= 4'h0;
    seen(0, t);
    seen(0, t);
    chk(t == 0 && o === 4'h0 && sreq === 1'b0, "stop");
  endtask
  // Low-active pin and a software request, oscillator slow to answer
  task t_ctl;
    int t;
    slow <= 1'b1;
    wc(32'h0000_0021);
    seen(0, t);
    chk(t > 2, "pin polarity");
    seen(1, t);
    chk(t > 2, "soft request");
    slow <= 1'b0;
  endtask
  task t_src;
    wc(32'h0000_1100);
    chk(sreq === 1'b1 && soe === 1'b1 && ins === 1'b1, "force");
    chk(acm === 1'b1 && acb === 1'b1, "ac bias");
    lo <= 1'b1;
    wc(32'h0000_0700);
    chk(sreq === 1'b0 && soe === 1'b1, "drain");
    wc(32'h0000_0b00);
    chk(soe === 1'b0, "source");
    lo <= 1'b0;
    wc(32'h0000_d000);
    chk(acb === 1'b0 && ins === 1'b0 && ldo === 1'b1, "idle");
    den <= 1'b0;
    req <= 4'h1;
    repeat (6) @(posedge clk_sys_i);
    chk(lp === 1'b1 && sreq === 1'b1, "low power");
    apb(1'b0, `QCRG_OFF_CTRL, 32'h0);
    chk(rd === 32'h0000_d000, "kept");
    den <= 1'b1;
    req <= 4'h0;
  endtask
  // Sticky flag survives the pin falling; a written one clears it
  task t_ot;
    ot <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    ot <= 1'b0;
    apb(1'b0, `QCRG_OFF_STATUS, 32'h0);
    chk(rd[0] === 1'b1, "hot flag");
    chk(ldo === 1'b0, "hot regulator off");
    apb(1'b1, `QCRG_OFF_STATUS, 32'h1);
    apb(1'b0, `QCRG_OFF_STATUS, 32'h0);
    chk(rd[0] === 1'b0, "flag clear");
  endtask
  task test_done;
    $display("failures %0d compares %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    {srst_i, den} = 2'b11;
    {psel, pen, pwr, ot, lo, slow} = 6'h00;
    {padr, pwd, req} = 48'h0;
    {failures, cmp_count} = 64'h0;
    repeat (6) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    @(posedge clk_sys_i);
    t_regs;
    t_gate;
    t_ctl;
    t_src;
    t_ot;
    test_done;
  end
  // The run needs about 1150 cycles; the watchdog allows far more
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    failures++;
    test_done;
  end
endmodule
